/* File: hw/iet_core.sv */
// How it works
// - States are sum of counts times weights.
// - Six separate cycle counts per instruction form.
// - Weights for on-chip memory and modules.
// - External three-state weights with wait states m.
// - Short branches take two fetches only.
// - Signed short branches time like others.
// - Extended map needs fourth byte nibble MSB zero.
// - Indirect bit prefixes take register from byte two.
// - Absolute bit prefixes take address from byte two.
`timescale 1ns/1ps
`default_nettype none
`include "iet_defines.svh"
module iet_core (
   // Clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   // Instruction request
   input  wire logic                 valid_i,
   input  wire logic [7:0]           byte0_i,
   input  wire logic [7:0]           byte1_i,
   input  wire logic [7:0]           byte2_i,
   input  wire logic [7:0]           byte3_i,
   // Access conditions
   input  wire iet_pkg::iet_tgt_t    fetch_tgt_i,
   input  wire iet_pkg::iet_tgt_t    stack_tgt_i,
   input  wire iet_pkg::iet_tgt_t    data_tgt_i,
   input  wire logic [2:0]           wait_i,
   // Decode result
   output logic                      done_o,
   output logic                      unknown_o,
   output iet_pkg::iet_form_t        form_o,
   output iet_pkg::iet_bitop_t       bit_op_o,
   output logic                      bit_reg_o,
   output logic [3:0]                bit_sel_o,
   output logic [2:0]                ptr_reg_o,
   output logic [7:0]                abs_addr_o,
   // Timing result
   output logic [3:0]                cnt_fetch_o,
   output logic [3:0]                cnt_branch_o,
   output logic [3:0]                cnt_stack_o,
   output logic [3:0]                cnt_byte_o,
   output logic [3:0]                cnt_word_o,
   output logic [3:0]                cnt_int_o,
   output logic [11:0]               states_o
);
   import iet_pkg::*;

   iet_state_t q_ff;
   iet_state_t nxt_q;

   // Wide means a fetch, vector, stack or word cycle; only byte cycles are narrow.
   function automatic logic [4:0] weight(input iet_tgt_t t, input logic wide,
                                         input logic [2:0] m);
      logic [4:0] w;
      w = `IET_W_ONCHIP;
      case (t)
         IET_TGT_MOD8:  w = wide ? `IET_W_MOD8_WIDE : `IET_W_MOD8_BYTE;
         IET_TGT_MOD16: w = `IET_W_MOD16;
         IET_TGT_E8_2:  w = wide ? `IET_W_E8_2_WIDE : `IET_W_E8_2_BYTE;
         IET_TGT_E8_3:  w = wide ? `IET_W_E8_3_WIDE + {1'b0, m, 1'b0}
                                 : `IET_W_E3_BASE + {2'b00, m};
         IET_TGT_E16_2: w = `IET_W_E16_2;
         IET_TGT_E16_3: w = `IET_W_E3_BASE + {2'b00, m};
         default:       w = `IET_W_ONCHIP;
      endcase
      return w;
   endfunction

   logic [4:0]  w_f, w_k, w_l, w_m;
   logic [11:0] sum;
   iet_form_t   f;
   iet_bitop_t  bop;
   logic        bit_ok;

   always_comb begin
      nxt_q = q_ff;
      nxt_q.done = 1'b0;
      f = IET_F_NONE;
      bop = IET_B_NONE;
      bit_ok = 1'b0;
      w_f = weight(fetch_tgt_i, 1'b1, wait_i);
      w_k = weight(stack_tgt_i, 1'b1, wait_i);
      w_l = weight(data_tgt_i, 1'b0, wait_i);
      w_m = weight(data_tgt_i, 1'b1, wait_i);
      // Bit operations on memory: odd prefix is the set/clear/invert/store group.
      if (byte0_i[0]) begin
         case (byte2_i[3:0])
            4'h0:    bop = IET_B_SET;
            4'h1:    bop = IET_B_INVERT;
            4'h2:    bop = IET_B_CLEAR;
            4'h7:    bop = IET_B_STORE;
            default: bop = IET_B_NONE;
         endcase
      end else begin
         case (byte2_i[3:0])
            4'h3:    bop = IET_B_TEST;
            4'h4:    bop = IET_B_OR;
            4'h5:    bop = IET_B_XOR;
            4'h6:    bop = IET_B_AND;
            4'h7:    bop = IET_B_LOAD;
            default: bop = IET_B_NONE;
         endcase
      end
      // Register-numbered forms exist for test/set/clear/invert only.
      // The store shares that third-byte nibble but keeps an immediate bit number.
      if (byte2_i[7:4] == `IET_NIB_BIT_REG) begin
         bit_ok = (bop == IET_B_TEST) || (bop == IET_B_SET) ||
                  (bop == IET_B_CLEAR) || (bop == IET_B_INVERT) ||
                  ((bop == IET_B_STORE) && !byte3_i[7]);
      end else if (byte2_i[7:4] == `IET_NIB_BIT_IMM) begin
         bit_ok = (bop != IET_B_NONE) && (bop != IET_B_STORE) && !byte3_i[7];
      end
      bit_ok = bit_ok && (byte3_i[3:0] == `IET_NIB_ZERO);
      if (byte0_i[7:4] == `IET_HI_BCC8) begin
         f = IET_F_BCC8;
      end else if (byte0_i[7:4] == `IET_HI_ADDB_IMM) begin
         f = IET_F_ADDB_IMM;
      end else if (byte0_i[7:4] == `IET_HI_ADDX_IMM) begin
         f = IET_F_ADDX;
      end else if (byte0_i[7:4] == `IET_HI_ANDB_IMM) begin
         f = IET_F_ANDB;
      end else begin
         case (byte0_i)
            `IET_OP_ADDB_REG: f = IET_F_ADDB_REG;
            `IET_OP_ADDW_REG: f = IET_F_ADDW_REG;
            `IET_OP_ADDL_REG: f = byte1_i[7] ? IET_F_ADDL_REG : IET_F_NONE;
            `IET_OP_ADDS:     f = IET_F_ADDS;
            `IET_OP_ADDX_REG: f = IET_F_ADDX;
            `IET_OP_ANDB_REG: f = IET_F_ANDB;
            `IET_OP_ANDW_REG: f = IET_F_ANDW_REG;
            `IET_OP_ANDC:     f = IET_F_ANDC;
            `IET_OP_BAND_REG: f = byte1_i[7] ? IET_F_NONE : IET_F_BAND_REG;
            `IET_OP_W_IMM: begin
               if (byte1_i[7:4] == `IET_NIB_ADD) f = IET_F_ADDW_IMM;
               else if (byte1_i[7:4] == `IET_NIB_AND) f = IET_F_ANDW_IMM;
            end
            `IET_OP_L_IMM: begin
               if (byte1_i[7:4] == `IET_NIB_ADD) f = IET_F_ADDL_IMM;
               else if (byte1_i[7:4] == `IET_NIB_AND) f = IET_F_ANDL_IMM;
            end
            `IET_OP_EXT: begin
               if (!byte3_i[7]) begin
                  if (byte1_i == `IET_EXT_LDC && byte2_i[7:4] == `IET_NIB_AND)
                     f = IET_F_LDC_EXT;
                  else if (byte1_i == `IET_EXT_SMUL && byte2_i[7:4] == `IET_NIB_MUL)
                     f = IET_F_SMUL;
                  else if (byte1_i == `IET_EXT_SDIV && byte2_i[7:4] == `IET_NIB_MUL)
                     f = IET_F_SDIV;
                  else if (byte1_i == `IET_EXT_LOGL && byte2_i[7:4] == `IET_NIB_AND)
                     f = IET_F_LOGL;
               end
            end
            default: begin
               if (byte0_i[7:1] == `IET_OP_BIT_IND && byte1_i[3:0] == `IET_NIB_ZERO
                   && bit_ok)
                  f = IET_F_BIT_IND;
               else if (byte0_i[7:1] == `IET_OP_BIT_ABS && bit_ok)
                  f = IET_F_BIT_ABS;
            end
         endcase
      end
      if (valid_i) begin
         nxt_q.done = 1'b1;
         nxt_q.form = f;
         nxt_q.unknown = (f == IET_F_NONE);
         nxt_q.bop = IET_B_NONE;
         nxt_q.bit_reg = 1'b0;
         nxt_q.bit_sel = `IET_NIB_ZERO;
         nxt_q.ptr_reg = 3'h0;
         nxt_q.abs_addr = 8'h00;
         nxt_q.ci = `IET_C_ZERO;
         nxt_q.cj = `IET_C_ZERO;
         nxt_q.ck = `IET_C_ZERO;
         nxt_q.cl = `IET_C_ZERO;
         nxt_q.cm = `IET_C_ZERO;
         nxt_q.cn = `IET_C_ZERO;
         if (f == IET_F_BIT_IND || f == IET_F_BIT_ABS) begin
            nxt_q.bop = bop;
            nxt_q.bit_reg = (byte2_i[7:4] == `IET_NIB_BIT_REG) && (bop != IET_B_STORE);
            nxt_q.bit_sel = byte3_i[7:4];
            if (f == IET_F_BIT_IND) nxt_q.ptr_reg = byte1_i[6:4];
            else nxt_q.abs_addr = byte1_i;
         end
         case (f)
            IET_F_BCC8: nxt_q.ci = `IET_C_TWO;
            IET_F_ADDW_IMM, IET_F_ANDW_IMM, IET_F_LOGL: nxt_q.ci = `IET_C_TWO;
            IET_F_ADDL_IMM, IET_F_ANDL_IMM: nxt_q.ci = `IET_C_THREE;
            IET_F_BAND_REG: nxt_q.ci = `IET_C_ONE;
            IET_F_BIT_IND, IET_F_BIT_ABS: begin
               nxt_q.ci = `IET_C_TWO;
               // Read-modify-write ops touch the byte twice, tests once.
               nxt_q.cl = (bop == IET_B_SET || bop == IET_B_CLEAR || bop == IET_B_INVERT
                           || bop == IET_B_STORE) ? `IET_C_TWO : `IET_C_ONE;
            end
            IET_F_LDC_EXT: begin
               nxt_q.ci = `IET_C_TWO;
               nxt_q.cm = `IET_C_ONE;
            end
            IET_F_SMUL: begin
               nxt_q.ci = `IET_C_TWO;
               nxt_q.cn = `IET_C_SMUL_N;
            end
            IET_F_SDIV: begin
               nxt_q.ci = `IET_C_TWO;
               nxt_q.cn = `IET_C_SDIV_N;
            end
            IET_F_NONE: nxt_q.ci = `IET_C_ZERO;
            default: nxt_q.ci = `IET_C_ONE;
         endcase
      end
      // Branch-address reads share the fetch target's weight.
      sum = 12'(nxt_q.ci * w_f) + 12'(nxt_q.cj * w_f) + 12'(nxt_q.ck * w_k)
          + 12'(nxt_q.cl * w_l) + 12'(nxt_q.cm * w_m)
          + 12'(nxt_q.cn * `IET_W_INTERNAL);
      if (valid_i) nxt_q.states = sum;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) q_ff <= '0;
      else q_ff <= nxt_q;
   end

   assign done_o       = q_ff.done;
   assign unknown_o    = q_ff.unknown;
   assign form_o       = q_ff.form;
   assign bit_op_o     = q_ff.bop;
   assign bit_reg_o    = q_ff.bit_reg;
   assign bit_sel_o    = q_ff.bit_sel;
   assign ptr_reg_o    = q_ff.ptr_reg;
   assign abs_addr_o   = q_ff.abs_addr;
   assign cnt_fetch_o  = q_ff.ci;
   assign cnt_branch_o = q_ff.cj;
   assign cnt_stack_o  = q_ff.ck;
   assign cnt_byte_o   = q_ff.cl;
   assign cnt_word_o   = q_ff.cm;
   assign cnt_int_o    = q_ff.cn;
   assign states_o     = q_ff.states;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_bcc_req;
      valid_i && byte0_i[7:4] == `IET_HI_BCC8;
   endsequence
   sequence s_two_fetch;
      done_o && cnt_fetch_o == `IET_C_TWO && cnt_byte_o == `IET_C_ZERO
      && cnt_word_o == `IET_C_ZERO && cnt_int_o == `IET_C_ZERO;
   endsequence

   a_bcc_two_fetch: assert property (s_bcc_req |=> s_two_fetch)
      else $error("short branch cycle counts wrong");
   a_signed_bcc: assert property (valid_i && byte0_i[7:2] == 6'h13
      && fetch_tgt_i == IET_TGT_ONCHIP |=> states_o == 12'h004)
      else $error("signed short branch timing wrong");
   a_ext_gate: assert property (valid_i && byte0_i == `IET_OP_EXT && byte3_i[7]
      |=> unknown_o)
      else $error("extended map decoded with fourth nibble msb set");
   a_ptr_field: assert property (valid_i && byte0_i[7:1] == `IET_OP_BIT_IND
      |=> unknown_o || ptr_reg_o == $past(byte1_i[6:4]))
      else $error("bit op pointer register wrong");
   a_abs_field: assert property (valid_i && byte0_i[7:1] == `IET_OP_BIT_ABS
      |=> unknown_o || abs_addr_o == $past(byte1_i))
      else $error("bit op absolute address wrong");
   a_onchip_weight: assert property (valid_i && fetch_tgt_i == IET_TGT_ONCHIP
      && stack_tgt_i == IET_TGT_ONCHIP && data_tgt_i == IET_TGT_ONCHIP
      |=> states_o == 12'(2 * (cnt_fetch_o + cnt_branch_o + cnt_stack_o + cnt_byte_o
          + cnt_word_o) + cnt_int_o))
      else $error("on-chip weighting wrong");
   a_ext16_wait: assert property (s_bcc_req and fetch_tgt_i == IET_TGT_E16_3
      |=> states_o == 12'(2 * (3 + $past(wait_i))))
      else $error("external 3-state weighting wrong");
   a_mod16_sum: assert property (valid_i && fetch_tgt_i == IET_TGT_MOD16
      && stack_tgt_i == IET_TGT_MOD16 && data_tgt_i == IET_TGT_MOD16
      |=> states_o == 12'(3 * (cnt_fetch_o + cnt_branch_o + cnt_stack_o + cnt_byte_o
          + cnt_word_o) + cnt_int_o))
      else $error("state sum wrong");
   a_andc_split: assert property (valid_i && byte0_i == `IET_OP_ANDC
      |=> cnt_fetch_o == `IET_C_ONE && cnt_byte_o == `IET_C_ZERO)
      else $error("separate cycle counts wrong");
   a_result_hold: assert property (done_o ##1 !done_o |-> $stable(states_o))
      else $error("result changed without a request");
endmodule
`default_nettype wire

/* File: hw/iet_defines.svh */
`ifndef IET_DEFINES_SVH
`define IET_DEFINES_SVH
// States per cycle for each access condition.
`define IET_W_ONCHIP     5'h02
`define IET_W_INTERNAL   5'h01
`define IET_W_MOD8_BYTE  5'h03
`define IET_W_MOD8_WIDE  5'h06
`define IET_W_MOD16      5'h03
`define IET_W_E8_2_BYTE  5'h02
`define IET_W_E8_2_WIDE  5'h04
`define IET_W_E3_BASE    5'h03
`define IET_W_E8_3_WIDE  5'h06
`define IET_W_E16_2      5'h02
// Cycle counts per instruction form.
`define IET_C_ZERO       4'h0
`define IET_C_ONE        4'h1
`define IET_C_TWO        4'h2
`define IET_C_THREE      4'h3
`define IET_C_SMUL_N     4'h2
`define IET_C_SDIV_N     4'h4
// Opcode bytes and nibbles.
`define IET_HI_BCC8      4'h4
`define IET_HI_ADDB_IMM  4'h8
`define IET_HI_ADDX_IMM  4'h9
`define IET_HI_ANDB_IMM  4'he
`define IET_NIB_ADD      4'h1
`define IET_NIB_AND      4'h6
`define IET_NIB_MUL      4'h5
`define IET_NIB_BIT_REG  4'h6
`define IET_NIB_BIT_IMM  4'h7
`define IET_NIB_ZERO     4'h0
`define IET_OP_EXT       8'h01
`define IET_OP_ANDC      8'h06
`define IET_OP_ADDB_REG  8'h08
`define IET_OP_ADDW_REG  8'h09
`define IET_OP_ADDL_REG  8'h0a
`define IET_OP_ADDS      8'h0b
`define IET_OP_ADDX_REG  8'h0e
`define IET_OP_ANDB_REG  8'h16
`define IET_OP_ANDW_REG  8'h66
`define IET_OP_BAND_REG  8'h76
`define IET_OP_W_IMM     8'h79
`define IET_OP_L_IMM     8'h7a
`define IET_OP_BIT_IND   7'h3e
`define IET_OP_BIT_ABS   7'h3f
`define IET_EXT_LDC      8'h40
`define IET_EXT_SMUL     8'hc0
`define IET_EXT_SDIV     8'hd0
`define IET_EXT_LOGL     8'hf0
`endif

/* File: hw/iet_pkg.sv */
package iet_pkg;
   typedef enum logic [2:0] {
      IET_TGT_ONCHIP = 3'b000, IET_TGT_MOD8 = 3'b001, IET_TGT_MOD16 = 3'b010,
      IET_TGT_E8_2 = 3'b011, IET_TGT_E8_3 = 3'b100, IET_TGT_E16_2 = 3'b101,
      IET_TGT_E16_3 = 3'b110
   } iet_tgt_t;
   typedef enum logic [4:0] {
      IET_F_NONE = 5'b00000, IET_F_BCC8 = 5'b00001, IET_F_ADDB_IMM = 5'b00010,
      IET_F_ADDB_REG = 5'b00011, IET_F_ADDW_IMM = 5'b00100, IET_F_ADDW_REG = 5'b00101,
      IET_F_ADDL_IMM = 5'b00110, IET_F_ADDL_REG = 5'b00111, IET_F_ADDS = 5'b01000,
      IET_F_ADDX = 5'b01001, IET_F_ANDB = 5'b01010, IET_F_ANDW_IMM = 5'b01011,
      IET_F_ANDW_REG = 5'b01100, IET_F_ANDL_IMM = 5'b01101, IET_F_ANDC = 5'b01110,
      IET_F_BAND_REG = 5'b01111, IET_F_BIT_IND = 5'b10000, IET_F_BIT_ABS = 5'b10001,
      IET_F_LDC_EXT = 5'b10010, IET_F_SMUL = 5'b10011, IET_F_SDIV = 5'b10100,
      IET_F_LOGL = 5'b10101
   } iet_form_t;
   typedef enum logic [3:0] {
      IET_B_NONE = 4'b0000, IET_B_TEST = 4'b0001, IET_B_SET = 4'b0010,
      IET_B_CLEAR = 4'b0011, IET_B_INVERT = 4'b0100, IET_B_AND = 4'b0101,
      IET_B_OR = 4'b0110, IET_B_XOR = 4'b0111, IET_B_LOAD = 4'b1000,
      IET_B_STORE = 4'b1001
   } iet_bitop_t;
   typedef struct packed {
      logic       done;
      logic       unknown;
      iet_form_t  form;
      iet_bitop_t bop;
      logic       bit_reg;
      logic [3:0] bit_sel;
      logic [2:0] ptr_reg;
      logic [7:0] abs_addr;
      logic [3:0] ci, cj, ck, cl, cm, cn;
      logic [11:0] states;
   } iet_state_t;
endpackage

/* File: tb/iet_access_env.sv */
`timescale 1ns/1ps
`default_nettype none
module iet_access_env
   import iet_pkg::*;
(
   // Access plan chosen by the bench
   input  wire logic [11:0]        cfg_i,
   // Access conditions seen by the core
   output var iet_pkg::iet_tgt_t   fetch_tgt_o,
   output var iet_pkg::iet_tgt_t   stack_tgt_o,
   output var iet_pkg::iet_tgt_t   data_tgt_o,
   output logic [2:0]              wait_o
);
   // Code 7 names no real bus, so it is folded onto on-chip memory here.
   always_comb begin
      fetch_tgt_o = (cfg_i[11:9] == 3'h7) ? IET_TGT_ONCHIP : iet_tgt_t'(cfg_i[11:9]);
      stack_tgt_o = (cfg_i[8:6] == 3'h7) ? IET_TGT_ONCHIP : iet_tgt_t'(cfg_i[8:6]);
      data_tgt_o  = (cfg_i[5:3] == 3'h7) ? IET_TGT_ONCHIP : iet_tgt_t'(cfg_i[5:3]);
      wait_o      = cfg_i[2:0];
   end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import iet_pkg::*;
   logic        mclk_i, rst_i, valid_i, done_o, unknown_o, bit_reg_o;
   logic [7:0]  b0, b1, b2, b3, abs_addr_o;
   logic [11:0] cfg, states_o;
   logic [2:0]  wt, ptr_reg_o;
   logic [3:0]  bit_sel_o, ci, cj, ck, cl, cm, cn;
   logic [31:0] w;
   iet_tgt_t    ft, st, dt;
   iet_form_t   form_o, lf;
   iet_bitop_t  bit_op_o, bo;
   int          compares, miscompares;
   logic [23:0] ext_op [7] = '{24'h01c050, 24'h01c052, 24'h01d051, 24'h01d053,
                               24'h01f064, 24'h01f065, 24'h01f066};
   int          ext_n [7] = '{2, 2, 4, 4, 0, 0, 0};
   logic [7:0]  alu_b0 [5] = '{8'h80, 8'h90, 8'he0, 8'h06, 8'h0b};
   iet_form_t   alu_f [5] = '{IET_F_ADDB_IMM, IET_F_ADDX, IET_F_ANDB, IET_F_ANDC, IET_F_ADDS};
   logic [15:0] op2 [12] = '{16'h0880, 16'h0912, 16'h0a91, 16'h0e12, 16'h1612, 16'h6612,
                             16'h7640, 16'h7910, 16'h7960, 16'h7a10, 16'h7a60, 16'h0a05};
   iet_form_t   op2_f [12] = '{IET_F_ADDB_REG, IET_F_ADDW_REG, IET_F_ADDL_REG, IET_F_ADDX,
                               IET_F_ANDB, IET_F_ANDW_REG, IET_F_BAND_REG, IET_F_ADDW_IMM,
                               IET_F_ANDW_IMM, IET_F_ADDL_IMM, IET_F_ANDL_IMM, IET_F_NONE};
   int          op2_i [12] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 3, 3, 0};

   iet_access_env env (.cfg_i(cfg), .fetch_tgt_o(ft), .stack_tgt_o(st), .data_tgt_o(dt),
                       .wait_o(wt));
   iet_core dut (.mclk_i(mclk_i), .rst_i(rst_i), .valid_i(valid_i), .byte0_i(b0),
                 .byte1_i(b1), .byte2_i(b2), .byte3_i(b3), .fetch_tgt_i(ft),
                 .stack_tgt_i(st), .data_tgt_i(dt), .wait_i(wt), .done_o(done_o),
                 .unknown_o(unknown_o), .form_o(form_o), .bit_op_o(bit_op_o),
                 .bit_reg_o(bit_reg_o), .bit_sel_o(bit_sel_o), .ptr_reg_o(ptr_reg_o),
                 .abs_addr_o(abs_addr_o), .cnt_fetch_o(ci), .cnt_branch_o(cj),
                 .cnt_stack_o(ck), .cnt_byte_o(cl), .cnt_word_o(cm), .cnt_int_o(cn),
                 .states_o(states_o));

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   // Fetch, branch-address, stack and word cycles share the wide cost.
   function automatic int wide(iet_tgt_t t, logic [2:0] m);
      case (t)
         IET_TGT_MOD8:  return 6;
         IET_TGT_MOD16: return 3;
         IET_TGT_E8_2:  return 4;
         IET_TGT_E8_3:  return 6 + 2 * int'(m);
         IET_TGT_E16_3: return 3 + int'(m);
         default:       return 2;
      endcase
   endfunction

   function automatic int narrow(iet_tgt_t t, logic [2:0] m);
      case (t)
         IET_TGT_MOD8, IET_TGT_MOD16: return 3;
         IET_TGT_E8_3, IET_TGT_E16_3: return 3 + int'(m);
         default:                     return 2;
      endcase
   endfunction

   task automatic summarize();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Valid stays high on return so the next call lands back to back.
   task automatic issue(input logic [31:0] v, input iet_form_t f, input iet_bitop_t eb,
                        input int i, input int l, input int n, input int m = 0);
      int         s;
      logic       bf;
      logic [7:0] a;
      logic [2:0] p;
      @(negedge mclk_i);
      cfg = {3'($urandom_range(6, 0)), 3'($urandom_range(6, 0)),
             3'($urandom_range(6, 0)), 3'($urandom)};
      {b0, b1, b2, b3} = v;
      valid_i = 1'b1;
      #1;
      s = i * wide(ft, wt) + l * narrow(dt, wt) + m * wide(dt, wt) + n;
      bf = (f == IET_F_BIT_IND) || (f == IET_F_BIT_ABS);
      p = (f == IET_F_BIT_IND) ? v[22:20] : 3'h0;
      a = (f == IET_F_BIT_ABS) ? v[23:16] : 8'h0;
      lf = f;
      @(posedge mclk_i);
      #1;
      `CHK({done_o, unknown_o}, {1'b1, f == IET_F_NONE})
      `CHK(form_o, f)
      `CHK(bit_op_o, eb)
      `CHK({bit_reg_o, bit_sel_o}, {bf && v[15:12] == 4'h6 && v[11:8] != 4'h7,
            bf ? v[7:4] : 4'h0})
      `CHK({ptr_reg_o, abs_addr_o}, {p, a})
      `CHK({ci, cj, ck, cl, cm, cn}, {4'(i), 8'h0, 4'(l), 4'(m), 4'(n)})
      `CHK(states_o, 12'(s))
   endtask

   initial begin
      void'($urandom(85933));
      rst_i = 1'b1;
      valid_i = 1'b0;
      cfg = 12'h0;
      {b0, b1, b2, b3} = 32'h0;
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_i = 1'b0;
      `CHK({done_o, unknown_o, form_o, bit_op_o, states_o, ci, cl}, 31'h0)
      for (int k = 0; k < 16; k++)
         issue({4'h4, 4'(k), 24'($urandom)}, IET_F_BCC8, IET_B_NONE, 2, 0, 0);
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 8; c++)
            for (int h = 6; h < 8; h++) begin
               if ((p % 2) ? (c > 2 && !(c == 7 && h == 6))
                           : (c < 3 || (h == 6 && c != 3)))
                  continue;
               bo = (p % 2) ? (c == 0 ? IET_B_SET : c == 1 ? IET_B_INVERT
                  : c == 2 ? IET_B_CLEAR : IET_B_STORE)
                  : (c == 3 ? IET_B_TEST : c == 4 ? IET_B_OR : c == 5 ? IET_B_XOR
                  : c == 6 ? IET_B_AND : IET_B_LOAD);
               w[31:24] = 8'h7c + 8'(p);
               w[23:16] = (p < 2) ? {1'b0, 3'($urandom), 4'h0} : 8'($urandom);
               w[15:8] = {4'(h), 4'(c)};
               w[7:0] = (h == 6 && c != 7) ? {4'($urandom), 4'h0}
                      : {1'b0, 3'($urandom), 4'h0};
               issue(w, p < 2 ? IET_F_BIT_IND : IET_F_BIT_ABS, bo, 2, (p % 2) ? 2 : 1, 0);
            end
      issue(32'h7c107390, IET_F_NONE, IET_B_NONE, 0, 0, 0);
      for (int k = 0; k < 7; k++) begin
         issue({ext_op[k], 1'b0, 7'($urandom)}, k < 2 ? IET_F_SMUL : k < 4 ? IET_F_SDIV
               : IET_F_LOGL, IET_B_NONE, 2, 0, ext_n[k]);
         issue({ext_op[k], 1'b1, 7'($urandom)}, IET_F_NONE, IET_B_NONE, 0, 0, 0);
      end
      for (int k = 0; k < 12; k++)
         issue({op2[k], 16'($urandom)}, op2_f[k], IET_B_NONE, op2_i[k], 0, 0);
      issue({24'h014069, 1'b0, 7'($urandom)}, IET_F_LDC_EXT, IET_B_NONE, 2, 0, 0, 1);
      issue(32'h7d307700, IET_F_NONE, IET_B_NONE, 0, 0, 0);
      issue(32'h7d306780, IET_F_NONE, IET_B_NONE, 0, 0, 0);
      for (int k = 0; k < 5; k++)
         issue({alu_b0[k] | ((k < 3) ? 8'($urandom_range(15, 0)) : 8'h0), 24'($urandom)},
               alu_f[k], IET_B_NONE, 1, 0, 0);
      @(negedge mclk_i);
      valid_i = 1'b0;
      @(posedge mclk_i);
      #1;
      `CHK({done_o, form_o}, {1'b0, lf})
      issue(32'h4c000000, IET_F_BCC8, IET_B_NONE, 2, 0, 0);
      @(negedge mclk_i);
      rst_i = 1'b1;
      @(posedge mclk_i);
      #1;
      `CHK({done_o, unknown_o, form_o, bit_op_o, states_o, ci, cl}, 31'h0)
      @(negedge mclk_i);
      rst_i = 1'b0;
      valid_i = 1'b0;
      issue(32'h7d307000, IET_F_BIT_IND, IET_B_SET, 2, 2, 0);
      summarize();
   end

   // Roughly 80 requests are issued, so this span leaves a wide margin.
   initial begin
      repeat (5000) @(posedge mclk_i);
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
